// ---- core/mmx_exec.sv ----
// Execution core for literal load, accumulator store and the two multiplies.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Function
// - Opcode 0110111a stores accumulator to file register.
// - Eight-bit file address spans a 256-byte bank.
// - Access bit clear: access bank; set: bank register.
// - Extended set, access clear, f<=5Fh: indexed offset.
// - Opcode 00001101 multiplies accumulator by literal.
// - Literal product to high/low product bytes, accumulator kept.
// - Opcode 0000001a multiplies accumulator by file register.
// - File multiply writes only the product pair.
// - Multiplies touch no status flag.
module mmx_exec
  import mmx_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [11:0]      file_addr,
  output logic             file_rd,
  input  wire logic [7:0]  file_rdata,
  output logic             file_wr,
  output logic [7:0]       file_wdata,
  output logic [7:0]       status_flags
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  mmx_phase_e  phase,  next_phase;
  logic [15:0] opcode, next_opcode;
  logic [7:0]  accumulator, next_accumulator;
  logic [7:0]  product_high_byte, next_product_high_byte;
  logic [7:0]  product_low_byte, next_product_low_byte;
  logic [7:0]  operand, next_operand;
  logic [3:0]  bank_select_register, next_bank_select_register;
  logic [11:0] index_base, next_index_base;
  logic        ext_enable, next_ext_enable;
  logic        aw_held, next_aw_held;
  logic        w_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0]  rresp, next_rresp;

  logic        is_load, is_store, is_mul_lit, is_mul_file, uses_file;
  logic        do_write, do_read, busy;
  logic [15:0] product;

  // Merges a write with its byte strobes over the low bits of a register.
  function automatic logic [31:0] mmx_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Resolves the 8-bit file field to a full data-space address.
  function automatic logic [11:0] mmx_file_addr(input logic [7:0]  f,
                                               input logic        a,
                                               input logic        ext,
                                               input logic [3:0]  bank,
                                               input logic [11:0] base);
    logic [11:0] res;
    res = {bank, f};
    if (!a) begin
      if (ext && (f <= MMX_INDEX_LIMIT)) begin
        res = base + {4'h0, f};
      end else if (f < MMX_ACCESS_SPLIT) begin
        res = {MMX_ACCESS_LO_BNK, f};
      end else begin
        res = {MMX_ACCESS_HI_BNK, f};
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  always_comb begin
    is_load     = (opcode[15:8] == MMX_OP_LOAD_LIT);
    is_mul_lit  = (opcode[15:8] == MMX_OP_MUL_LIT);
    is_mul_file = (opcode[15:9] == MMX_OP_MUL_FILE);
    is_store    = (opcode[15:9] == MMX_OP_STORE);
    uses_file   = is_mul_file || is_store;
    product     = {8'h00, accumulator} * {8'h00, operand};
    file_addr   = mmx_file_addr(opcode[7:0], opcode[8], ext_enable,
                                bank_select_register, index_base);
    file_rd     = (phase == MMX_PH_READ) && is_mul_file;
    file_wr     = (phase == MMX_PH_WRITE) && is_store;
    file_wdata  = accumulator;
    // Status flags are never driven by these instructions.
    status_flags = 8'h00;
    busy        = (phase != MMX_PH_IDLE);
  end

  // ---------------------------------------------------------------------------
  // Bus handshakes
  // ---------------------------------------------------------------------------
  always_comb begin
    s_axi_awready = !aw_held && !bvalid;
    s_axi_wready  = !w_held && !bvalid;
    s_axi_arready = !rvalid;
    s_axi_bvalid  = bvalid;
    s_axi_bresp   = bresp;
    s_axi_rvalid  = rvalid;
    s_axi_rdata   = rdata;
    s_axi_rresp   = rresp;
    next_aw_held  = aw_held || (s_axi_awvalid && s_axi_awready);
    next_w_held   = w_held || (s_axi_wvalid && s_axi_wready);
    next_aw_addr  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
    next_w_data   = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
    next_w_strb   = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
    do_write      = aw_held && w_held && !bvalid;
    do_read       = s_axi_arvalid && s_axi_arready;
    next_bvalid   = bvalid;
    next_bresp    = bresp;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = MMX_RESP_OKAY;
      if (aw_addr > MMX_REG_STATUS || aw_addr[1:0] != 2'b00) begin
        next_bresp = MMX_RESP_SLVERR;
      end
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp  = MMX_RESP_OKAY;
      case (s_axi_araddr)
        MMX_REG_CTRL:   next_rdata = {31'h0, ext_enable};
        MMX_REG_OPCODE: next_rdata = {16'h0, opcode};
        MMX_REG_ACC:    next_rdata = {24'h0, accumulator};
        MMX_REG_PROD:   next_rdata = {16'h0, product_high_byte, product_low_byte};
        MMX_REG_BANK:   next_rdata = {28'h0, bank_select_register};
        MMX_REG_INDEX:  next_rdata = {20'h0, index_base};
        MMX_REG_STATUS: next_rdata = {31'h0, busy};
        default: begin
          next_rdata = 32'h0;
          next_rresp = MMX_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Instruction cycle and architectural registers
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [31:0] merged;
    merged                    = 32'h0;
    next_phase                = phase;
    next_opcode               = opcode;
    next_accumulator          = accumulator;
    next_product_high_byte    = product_high_byte;
    next_product_low_byte     = product_low_byte;
    next_operand              = operand;
    next_bank_select_register = bank_select_register;
    next_index_base           = index_base;
    next_ext_enable           = ext_enable;
    case (phase)
      MMX_PH_IDLE:    next_phase = MMX_PH_IDLE;
      MMX_PH_DECODE:  next_phase = MMX_PH_READ;
      MMX_PH_READ: begin
        next_operand = is_mul_file ? file_rdata : opcode[7:0];
        next_phase   = MMX_PH_PROCESS;
      end
      MMX_PH_PROCESS: next_phase = MMX_PH_WRITE;
      MMX_PH_WRITE: begin
        if (is_load) begin
          next_accumulator = opcode[7:0];
        end
        if (is_mul_lit || is_mul_file) begin
          // Only the product pair changes; accumulator and file stay put.
          next_product_high_byte = product[15:8];
          next_product_low_byte  = product[7:0];
        end
        next_phase = MMX_PH_IDLE;
      end
      default: next_phase = MMX_PH_IDLE;
    endcase
    // Software writes land only while no instruction is in flight, so an
    // instruction never sees its own operands change mid-cycle.
    if (do_write && !busy) begin
      case (aw_addr)
        MMX_REG_CTRL: begin
          merged          = mmx_merge({31'h0, ext_enable}, w_data, w_strb);
          next_ext_enable = merged[MMX_CTRL_EXT_BIT];
        end
        MMX_REG_OPCODE: begin
          merged      = mmx_merge({16'h0, opcode}, w_data, w_strb);
          next_opcode = merged[15:0];
          next_phase  = MMX_PH_DECODE;
        end
        MMX_REG_ACC: begin
          merged           = mmx_merge({24'h0, accumulator}, w_data, w_strb);
          next_accumulator = merged[7:0];
        end
        MMX_REG_BANK: begin
          merged                    = mmx_merge({28'h0, bank_select_register},
                                                w_data, w_strb);
          next_bank_select_register = merged[3:0];
        end
        MMX_REG_INDEX: begin
          merged          = mmx_merge({20'h0, index_base}, w_data, w_strb);
          next_index_base = merged[11:0];
        end
        default: merged = 32'h0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase                <= MMX_PH_IDLE;
      opcode               <= 16'h0000;
      accumulator          <= 8'h00;
      product_high_byte    <= 8'h00;
      product_low_byte     <= 8'h00;
      operand              <= 8'h00;
      bank_select_register <= 4'h0;
      index_base           <= MMX_INDEX_BASE_RST;
      ext_enable           <= 1'b0;
      aw_held              <= 1'b0;
      w_held               <= 1'b0;
      aw_addr              <= 8'h00;
      w_data               <= 32'h0;
      w_strb               <= 4'h0;
      bvalid               <= 1'b0;
      bresp                <= MMX_RESP_OKAY;
      rvalid               <= 1'b0;
      rdata                <= 32'h0;
      rresp                <= MMX_RESP_OKAY;
    end else begin
      phase                <= next_phase;
      opcode               <= next_opcode;
      accumulator          <= next_accumulator;
      product_high_byte    <= next_product_high_byte;
      product_low_byte     <= next_product_low_byte;
      operand              <= next_operand;
      bank_select_register <= next_bank_select_register;
      index_base           <= next_index_base;
      ext_enable           <= next_ext_enable;
      aw_held              <= next_aw_held;
      w_held               <= next_w_held;
      aw_addr              <= next_aw_addr;
      w_data               <= next_w_data;
      w_strb               <= next_w_strb;
      bvalid               <= next_bvalid;
      bresp                <= next_bresp;
      rvalid               <= next_rvalid;
      rdata                <= next_rdata;
      rresp                <= next_rresp;
    end
  end

endmodule // mmx_exec

// ---- core/mmx_pkg.sv ----
// Package of constants and types for the move and multiply execution block.
package mmx_pkg;

  // ---------------------------------------------------------------------------
  // Opcode patterns: upper byte for literal load and multiply, upper seven bits for file multiply and store
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MMX_OP_LOAD_LIT  = 8'h0e;
  localparam logic [7:0] MMX_OP_MUL_LIT   = 8'h0d;
  localparam logic [6:0] MMX_OP_MUL_FILE  = 7'h01;
  localparam logic [6:0] MMX_OP_STORE     = 7'h37;

  // ---------------------------------------------------------------------------
  // Addressing
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  MMX_INDEX_LIMIT   = 8'h5f;
  localparam logic [7:0]  MMX_ACCESS_SPLIT  = 8'h60;
  localparam logic [3:0]  MMX_ACCESS_LO_BNK = 4'h0;
  localparam logic [3:0]  MMX_ACCESS_HI_BNK = 4'hf;
  localparam logic [11:0] MMX_INDEX_BASE_RST = 12'h000;

  // ---------------------------------------------------------------------------
  // AXI4-Lite register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MMX_REG_CTRL   = 8'h00;
  localparam logic [7:0] MMX_REG_OPCODE = 8'h04;
  localparam logic [7:0] MMX_REG_ACC    = 8'h08;
  localparam logic [7:0] MMX_REG_PROD   = 8'h0c;
  localparam logic [7:0] MMX_REG_BANK   = 8'h10;
  localparam logic [7:0] MMX_REG_INDEX  = 8'h14;
  localparam logic [7:0] MMX_REG_STATUS = 8'h18;
  localparam logic [1:0] MMX_RESP_OKAY   = 2'b00;
  localparam logic [1:0] MMX_RESP_SLVERR = 2'b10;
  localparam int         MMX_CTRL_EXT_BIT = 0;

  // ---------------------------------------------------------------------------
  // Instruction cycle phases
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    MMX_PH_IDLE    = 5'b00001,
    MMX_PH_DECODE  = 5'b00010,
    MMX_PH_READ    = 5'b00100,
    MMX_PH_PROCESS = 5'b01000,
    MMX_PH_WRITE   = 5'b10000
  } mmx_phase_e;

endpackage

// ---- tb/mmx_exec_props.sv ----
// Port checker for the move and multiply execution core.
`timescale 1ns/1ps
module mmx_exec_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        file_rd,
  input wire logic        file_wr,
  input wire logic [7:0]  file_wdata,
  input wire logic [7:0]  status_flags
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------------------------
  // Instruction and bus relations
  // ---------------------------------------------------------------
  // A file multiply reads its operand but must never write the file in its tail.
  sequence s_no_write_tail;
    !file_wr [*3];
  endsequence
  a_flags_zero: assert property (status_flags == 8'h00)
    else $error("status flags changed");
  a_rd_single: assert property (file_rd |=> !file_rd)
    else $error("file read held longer than one phase");
  a_wr_single: assert property (file_wr |=> !file_wr)
    else $error("file write held longer than one phase");
  a_mul_no_write: assert property (file_rd |-> s_no_write_tail)
    else $error("file multiply wrote the file");
  a_wdata_steady: assert property (file_wr |-> $stable(file_wdata))
    else $error("store data moved during the instruction");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before acceptance");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels open while response pending");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while data pending");
endmodule // mmx_exec_props

// ---- tb/mmx_file_model.sv ----
// Behavioural data register file on the far side of the core's file port.
`timescale 1ns/1ps
module mmx_file_model (
  input  wire logic        aclk,
  input  wire logic [11:0] file_addr,
  input  wire logic        file_rd,
  input  wire logic        file_wr,
  input  wire logic [7:0]  file_wdata,
  output logic [7:0]       file_rdata
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] mem [4096];
  logic [7:0] last = 8'h00;
  // Outside a read the bus shows the inverse of the last data, so stale data never matches.
  assign file_rdata = file_rd ? mem[file_addr] : ~last;
  always @(posedge aclk) begin
    if (file_wr) mem[file_addr] <= file_wdata;
    if (file_rd) last <= mem[file_addr];
  end
endmodule // mmx_file_model

// ---- tb/mmx_exec_tb.sv ----
// Self-checking bench for the move and multiply execution core.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module mmx_exec_tb;
  import mmx_pkg::*;
  logic aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, file_rdata, file_wdata, status_flags;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, file_rd, file_wr;
  logic [11:0] file_addr;
  int fails = 0, n_compared = 0;
  mmx_exec u_mmx_exec (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .file_addr, .file_rd, .file_rdata, .file_wr, .file_wdata,
    .status_flags);
  mmx_file_model u_mmx_file_model (.aclk, .file_addr, .file_rd, .file_wr, .file_wdata,
    .file_rdata);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task timed_out;
    fails++;
    $display("Error handshake expected answer seen none");
    report_and_stop();
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin r = s_axi_bresp; s_axi_bready <= 1'b0; break; end
    end
    if (n == 40) timed_out();
  endtask
  // Ready is raised late on purpose so the slave must hold its answer.
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0; break;
      end
      if (n == 1) s_axi_rready <= 1'b1;
    end
    if (n == 40) timed_out();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d; logic [1:0] r;
    axi_read(a, d, r);
    `CHK(nm, e, d);
  endtask
  task automatic run_op(input logic [15:0] op);
    logic [31:0] d; logic [1:0] r; int n;
    wr(MMX_REG_OPCODE, {16'h0000, op});
    for (n = 0; n < 10; n++) begin
      axi_read(MMX_REG_STATUS, d, r);
      if (d[0] === 1'b0) break;
    end
    if (n == 10) timed_out();
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_unmapped;
    logic [31:0] d; logic [1:0] r, w;
    axi_read(8'h1c, d, r);
    axi_write(8'h1c, 32'h0000_00ff, w);
    `CHK("unmapped rresp", MMX_RESP_SLVERR, r);
    `CHK("unmapped rdata", 32'h0, d);
    `CHK("unmapped bresp", MMX_RESP_SLVERR, w);
  endtask
  task automatic t_store_modes;
    logic ex [6] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
    logic [8:0] af [6] = '{9'h1a5, 9'h020, 9'h070, 9'h05f, 9'h060, 9'h1ff};
    logic [11:0] ea [6] = '{12'h3a5, 12'h020, 12'hf70, 12'h25f, 12'hf60, 12'hdff};
    int i;
    wr(MMX_REG_INDEX, 32'h0000_0200);
    for (i = 0; i < 6; i++) begin
      wr(MMX_REG_CTRL, {31'h0, ex[i]});
      wr(MMX_REG_BANK, {28'h0, af[i][8] ? ea[i][11:8] : 4'h7});
      run_op({8'h0e, 8'h40 + i[7:0]});
      run_op({7'h37, af[i]});
      `CHK("stored byte", 8'h40 + i[7:0], u_mmx_file_model.mem[ea[i]]);
    end
  endtask
  task automatic t_mul_lit;
    wr(MMX_REG_CTRL, 32'h0);
    run_op(16'h0ee2);
    run_op(16'h0dc4);
    rd_chk(MMX_REG_PROD, 32'h0000_ad08, "literal product");
    rd_chk(MMX_REG_ACC, 32'h0000_00e2, "accumulator");
    run_op(16'h0d00);
    rd_chk(MMX_REG_PROD, 32'h0, "zero product");
    `CHK("status flags", 8'h00, status_flags);
  endtask
  task automatic t_mul_file;
    run_op(16'h0eb5);
    run_op(16'h6e45);
    run_op(16'h0ec4);
    run_op(16'h0245);
    rd_chk(MMX_REG_PROD, 32'h0000_8a94, "file product");
    rd_chk(MMX_REG_ACC, 32'h0000_00c4, "accumulator");
    `CHK("source byte", 8'hb5, u_mmx_file_model.mem[12'h045]);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_unmapped();
    t_store_modes();
    t_mul_lit();
    t_mul_file();
    report_and_stop();
  end
endmodule // mmx_exec_tb
bind mmx_exec mmx_exec_props u_mmx_exec_props (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .file_rd,
  .file_wr, .file_wdata, .status_flags);
